// ### hdl/dcwd_decoder.sv
//----------------------------------------------------------------------
// Purpose: decode the drive command word, stop mode and control type
// Assumes: sources present writes on ref_clk; digital inputs are pins
// Notes: all outputs are registered; ramp timing lives elsewhere
//----------------------------------------------------------------------
`timescale 1ns/100ps

module dcwd_decoder (
   // clock and reset
   input logic ref_clk,
   input logic reset,
   // command word access
   input logic [1:0] activeSrc,
   input logic wrEn,
   input logic [1:0] wrSrc,
   input logic [15:0] wrData,
   // configuration settings
   input logic stopModeWr,
   input logic ctrlTypeWr,
   input logic [15:0] cfgData,
   // drive state
   input logic faultState,
   // pins
   input logic diStopPin,
   input logic frameSmallPin,
   // read back
   output logic [15:0] cmdWordRd,
   output logic [15:0] stopModeRd,
   output logic [15:0] ctrlTypeRd,
   output logic wrRejected,
   // decoded commands
   output logic runReq,
   output logic rampDown,
   output logic driveEnable,
   output logic coastCut,
   output logic dirCw,
   output logic inchingActive,
   output logic remoteMode,
   output logic rampSet2,
   output logic quickStopActive,
   output logic faultClear,
   output logic intManual,
   output logic extManual,
   output logic [1:0] decelSel,
   output logic [2:0] ctrlMode,
   output logic configState
);

   //-------------------------------------------------------------------
   // pin synchronisers
   //-------------------------------------------------------------------
   logic diStopMeta;
   logic diStopSync;
   logic frameMeta;
   logic frameSync;
   logic next_diStopMeta;
   logic next_diStopSync;
   logic next_frameMeta;
   logic next_frameSync;

   always_comb begin
      next_diStopMeta = diStopPin;
      next_diStopSync = diStopMeta;
      next_frameMeta = frameSmallPin;
      next_frameSync = frameMeta;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         diStopMeta <= 1'b0;
         diStopSync <= 1'b0;
         frameMeta <= 1'b0;
         frameSync <= 1'b0;
      end else begin
         diStopMeta <= next_diStopMeta;
         diStopSync <= next_diStopSync;
         frameMeta <= next_frameMeta;
         frameSync <= next_frameSync;
      end
   end

   //-------------------------------------------------------------------
   // settings and command word storage
   //-------------------------------------------------------------------
   logic [15:0] cmdWord;
   logic [15:0] stopMode;
   logic [15:0] ctrlType;
   logic [15:0] next_cmdWord;
   logic [15:0] next_stopMode;
   logic [15:0] next_ctrlType;
   logic next_wrRejected;
   logic srcMayWrite;
   logic wrAccept;

   always_comb begin
      // panel and digital inputs act through their own functions
      srcMayWrite = (wrSrc == dcwd_pkg::SRC_NET) ||
                    (wrSrc == dcwd_pkg::SRC_LOGIC);
      wrAccept = wrEn && srcMayWrite &&
                 (wrSrc == activeSrc);
      next_wrRejected = wrEn && !wrAccept;
      // reserved bits are stored but drive nothing
      next_cmdWord = wrAccept ? wrData : cmdWord;
      next_stopMode = stopMode;
      if (stopModeWr && (cfgData <= dcwd_pkg::STOP_QUICK)) begin
         next_stopMode = cfgData;
      end
      next_ctrlType = ctrlType;
      // unused codes leave the previous method in force
      if (ctrlTypeWr && (cfgData <= dcwd_pkg::CT_PMVECT) &&
          (cfgData != dcwd_pkg::CT_NOFUNC1) &&
          (cfgData != dcwd_pkg::CT_NOFUNC2)) begin
         next_ctrlType = cfgData;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cmdWord <= dcwd_pkg::CMD_RESET;
         stopMode <= dcwd_pkg::STOP_RAMP;
         ctrlType <= dcwd_pkg::CT_SCALAR;
         wrRejected <= 1'b0;
      end else begin
         cmdWord <= next_cmdWord;
         stopMode <= next_stopMode;
         ctrlType <= next_ctrlType;
         wrRejected <= next_wrRejected;
      end
   end

   // every source may read the stored values
   assign cmdWordRd = cmdWord;
   assign stopModeRd = stopMode;
   assign ctrlTypeRd = ctrlType;

   //-------------------------------------------------------------------
   // command decode
   //-------------------------------------------------------------------
   logic isCoast;
   logic isQuickMode;
   logic stopAsked;
   logic pmBlocked;
   logic next_runReq;
   logic next_rampDown;
   logic next_driveEnable;
   logic next_coastCut;
   logic next_dirCw;
   logic next_inching;
   logic next_remote;
   logic next_rampSet2;
   logic next_quickStop;
   logic next_faultClear;
   logic next_intManual;
   logic next_extManual;
   logic [1:0] next_decelSel;
   logic [2:0] next_ctrlMode;
   logic next_configState;

   always_comb begin
      isCoast = (stopMode == dcwd_pkg::STOP_COAST);
      isQuickMode = (stopMode == dcwd_pkg::STOP_QUICK);
      // a stop from bit 0 or from a digital input stop function
      stopAsked = !cmdWord[dcwd_pkg::B_RUN] || diStopSync;
      // pm control missing on the small frame
      pmBlocked = frameSync &&
                  (ctrlType == dcwd_pkg::CT_PMVECT);
      next_configState = pmBlocked;
      next_ctrlMode = ctrlType[2:0];
      next_runReq = !stopAsked;
      // coast turns a stop into a loss of drive, no ramp
      next_coastCut = isCoast && stopAsked;
      next_driveEnable = cmdWord[dcwd_pkg::B_ENABLE] &&
                         !pmBlocked &&
                         !next_coastCut;
      next_rampDown = stopAsked && !isCoast &&
                      next_driveEnable;
      next_dirCw = cmdWord[dcwd_pkg::B_CW];
      next_inching = cmdWord[dcwd_pkg::B_INCH];
      next_remote = cmdWord[dcwd_pkg::B_REMOTE];
      next_rampSet2 = cmdWord[dcwd_pkg::B_RAMP2];
      next_quickStop = cmdWord[dcwd_pkg::B_QSTOP];
      // held until the fault source drops its fault state
      next_faultClear = cmdWord[dcwd_pkg::B_FRESET] &&
                        faultState;
      next_intManual = cmdWord[dcwd_pkg::B_INTMAN];
      next_extManual = cmdWord[dcwd_pkg::B_EXTMAN];
      if (isQuickMode || cmdWord[dcwd_pkg::B_QSTOP]) begin
         next_decelSel = dcwd_pkg::DEC_QUICK;
      end else if (cmdWord[dcwd_pkg::B_RAMP2]) begin
         next_decelSel = dcwd_pkg::DEC_SECOND;
      end else begin
         next_decelSel = dcwd_pkg::DEC_FIRST;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         runReq <= 1'b0;
         rampDown <= 1'b0;
         driveEnable <= 1'b0;
         coastCut <= 1'b0;
         dirCw <= 1'b0;
         inchingActive <= 1'b0;
         remoteMode <= 1'b0;
         rampSet2 <= 1'b0;
         quickStopActive <= 1'b0;
         faultClear <= 1'b0;
         intManual <= 1'b0;
         extManual <= 1'b0;
         decelSel <= dcwd_pkg::DEC_FIRST;
         ctrlMode <= dcwd_pkg::CT_SCALAR[2:0];
         configState <= 1'b0;
      end else begin
         runReq <= next_runReq;
         rampDown <= next_rampDown;
         driveEnable <= next_driveEnable;
         coastCut <= next_coastCut;
         dirCw <= next_dirCw;
         inchingActive <= next_inching;
         remoteMode <= next_remote;
         rampSet2 <= next_rampSet2;
         quickStopActive <= next_quickStop;
         faultClear <= next_faultClear;
         intManual <= next_intManual;
         extManual <= next_extManual;
         decelSel <= next_decelSel;
         ctrlMode <= next_ctrlMode;
         configState <= next_configState;
      end
   end

endmodule : dcwd_decoder

// ### hdl/dcwd_pkg.sv
//----------------------------------------------------------------------
// Purpose: constants for the drive command word decoder
// Assumes: one system clock, asynchronous active-high reset
// Notes: bit positions, setting codes and source codes live here
//----------------------------------------------------------------------
// How it works
// - only the selected command source writes the word; all may read
// - bit 0 set runs up the accel ramp, clear ramps down
// - bit 1 clear cuts motor power, set allows operation
// - bit 2 set turns clockwise, clear counter-clockwise
// - bit 3 enables the inching function
// - bit 4 set selects remote, clear selects local
// - bit 5 picks the second accel/decel time pair
// - bit 6 enables quick stop
// - bit 7 clears a pending fault
// - bit 13 sets internal regulator manual, clear automatic
// - bit 14 sets external regulator manual, clear automatic
// - stop mode 0 ramp, 1 coast, 2 quick; resets to 0
// - mode 0 decelerates with the active ramp set decel time
// - mode 1 cuts drive so the motor coasts to rest
// - mode 2 decelerates with the quick-stop decel time
// - in coast mode clearing bit 0 acts like clearing bit 1
// - in coast mode digital input stop functions cut drive too
// - front panel and digital inputs never write the word
// - control type 0 scalar, 3 vector-volt, 4 sensorless, 5 pm mode
// - control types 1 and 2 have no function
// - pm mode on the small frame forces the configuration state
//----------------------------------------------------------------------
package dcwd_pkg;
   localparam int WORD_W = 16;
   // command word bit positions
   localparam int B_RUN = 0;
   localparam int B_ENABLE = 1;
   localparam int B_CW = 2;
   localparam int B_INCH = 3;
   localparam int B_REMOTE = 4;
   localparam int B_RAMP2 = 5;
   localparam int B_QSTOP = 6;
   localparam int B_FRESET = 7;
   localparam int B_INTMAN = 13;
   localparam int B_EXTMAN = 14;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   // command sources
   typedef enum logic [1:0] {
      SRC_PANEL = 2'b00,
      SRC_DIGIN = 2'b01,
      SRC_NET = 2'b10,
      SRC_LOGIC = 2'b11
   } dcwd_src_t;
   // stop mode codes
   localparam logic [15:0] STOP_RAMP = 16'h0000;
   localparam logic [15:0] STOP_COAST = 16'h0001;
   localparam logic [15:0] STOP_QUICK = 16'h0002;
   // control type codes
   localparam logic [15:0] CT_SCALAR = 16'h0000;
   localparam logic [15:0] CT_NOFUNC1 = 16'h0001;
   localparam logic [15:0] CT_NOFUNC2 = 16'h0002;
   localparam logic [15:0] CT_VVECT = 16'h0003;
   localparam logic [15:0] CT_SENSLESS = 16'h0004;
   localparam logic [15:0] CT_PMVECT = 16'h0005;
   // deceleration time selector
   typedef enum logic [1:0] {
      DEC_FIRST = 2'b00,
      DEC_SECOND = 2'b01,
      DEC_QUICK = 2'b10
   } dcwd_dec_t;
endpackage : dcwd_pkg

// ### tb/dcwd_cmd_src.sv
// Purpose: network master model that writes the command word
// Assumes: one write strobe a call, changed just after a rising edge
// Notes: data is turned over after release so stale values never match
`timescale 1ns/100ps
module dcwd_cmd_src (
   // clock
   input logic ref_clk,
   // command word write side
   output logic wrEn,
   output logic [1:0] wrSrc,
   output logic [15:0] wrData
);
   initial begin
      wrEn = 1'b0;
      wrSrc = 2'h2;
      wrData = 16'h0000;
   end
   task automatic send(input logic [1:0] s, input logic [15:0] d);
      @(posedge ref_clk);
      wrEn <= 1'b1;
      wrSrc <= s;
      wrData <= d;
      @(posedge ref_clk);
      wrEn <= 1'b0;
      wrData <= ~d;
   endtask : send
endmodule : dcwd_cmd_src

// ### tb/dcwd_decoder_sva.sv
// Purpose: port assertions for the command word decoder
// Assumes: ref_clk domain only, reset disables every property
// Notes: decoded outputs lag the stored word by one edge
`timescale 1ns/100ps
module dcwd_decoder_chk (
   // watched ports
   input logic ref_clk,
   input logic reset,
   input logic [1:0] activeSrc,
   input logic wrEn,
   input logic [1:0] wrSrc,
   input logic [15:0] wrData,
   input logic stopModeWr,
   input logic ctrlTypeWr,
   input logic [15:0] cfgData,
   input logic faultState,
   input logic [15:0] cmdWordRd,
   input logic [15:0] stopModeRd,
   input logic [15:0] ctrlTypeRd,
   input logic wrRejected,
   input logic coastCut,
   input logic dirCw,
   input logic faultClear,
   input logic [1:0] decelSel,
   input logic configState
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic take;
   assign take = wrEn && wrSrc == activeSrc && wrSrc[1];
   property p_take; take |=> cmdWordRd == $past(wrData); endproperty
   a_take: assert property (p_take) else $error("write lost");
   property p_refuse;
      wrEn && !take |=> wrRejected && $stable(cmdWordRd);
   endproperty
   a_refuse: assert property (p_refuse) else $error("bad write");
   property p_dir; dirCw == $past(cmdWordRd[2]); endproperty
   a_dir: assert property (p_dir) else $error("direction");
   property p_fault; faultClear == $past(cmdWordRd[7] && faultState);
   endproperty
   a_fault: assert property (p_fault) else $error("fault clear");
   property p_coast;
      stopModeRd == dcwd_pkg::STOP_COAST && !cmdWordRd[0] |=> coastCut;
   endproperty
   a_coast: assert property (p_coast) else $error("no coast");
   property p_quick;
      stopModeRd == dcwd_pkg::STOP_QUICK |=> decelSel == 2'h2;
   endproperty
   a_quick: assert property (p_quick) else $error("quick decel");
   property p_ramp;
      stopModeRd == dcwd_pkg::STOP_RAMP && !cmdWordRd[6]
         |=> decelSel == {1'b0, $past(cmdWordRd[5])};
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp decel");
   property p_stopw;
      stopModeWr && cfgData > 16'h0002 |=> $stable(stopModeRd);
   endproperty
   a_stopw: assert property (p_stopw) else $error("stop mode");
   property p_ctw;
      ctrlTypeWr && cfgData inside {16'h0001, 16'h0002}
         |=> $stable(ctrlTypeRd);
   endproperty
   a_ctw: assert property (p_ctw) else $error("control type");
   property p_cfg;
      configState |-> $past(ctrlTypeRd) == dcwd_pkg::CT_PMVECT;
   endproperty
   a_cfg: assert property (p_cfg) else $error("config state");
   c_coast: cover property (coastCut);
   c_rej: cover property (wrRejected);
   c_cfg: cover property (configState);
endmodule : dcwd_decoder_chk
bind dcwd_decoder dcwd_decoder_chk chk (.ref_clk, .reset, .activeSrc,
   .wrEn, .wrSrc, .wrData, .stopModeWr, .ctrlTypeWr, .cfgData, .faultState,
   .cmdWordRd, .stopModeRd, .ctrlTypeRd, .wrRejected, .coastCut, .dirCw,
   .faultClear, .decelSel, .configState);

// ### tb/tb_top.sv
// Purpose: self-checking bench for the command word decoder
// Assumes: 20 MHz clock, reset high for ten cycles
// Notes: decoded outputs are sampled two edges after a write
`timescale 1ns/100ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
   n_mismatch++; $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_top;
   logic ref_clk = 1'b0, reset = 1'b1, stopModeWr = 1'b0;
   logic ctrlTypeWr = 1'b0, faultState = 1'b0, diStopPin = 1'b0;
   logic frameSmallPin = 1'b0, wrEn, wrRejected, runReq, rampDown;
   logic driveEnable, coastCut, dirCw, inchingActive, remoteMode, rampSet2;
   logic quickStopActive, faultClear, intManual, extManual, configState;
   logic [1:0] activeSrc = 2'h2, wrSrc, decelSel;
   logic [2:0] ctrlMode;
   logic [15:0] cfgData = 16'h0000, wrData, cmdWordRd, stopModeRd, ctrlTypeRd;
   logic [15:0] w, e;
   int n_mismatch = 0, total_checks = 0;
   always #25 ref_clk = ~ref_clk;
   dcwd_cmd_src src (.ref_clk, .wrEn, .wrSrc, .wrData);
   dcwd_decoder DUT (.ref_clk, .reset, .activeSrc, .wrEn, .wrSrc, .wrData,
      .stopModeWr, .ctrlTypeWr, .cfgData, .faultState, .diStopPin,
      .frameSmallPin, .cmdWordRd, .stopModeRd, .ctrlTypeRd, .wrRejected,
      .runReq, .rampDown, .driveEnable, .coastCut, .dirCw, .inchingActive,
      .remoteMode, .rampSet2, .quickStopActive, .faultClear, .intManual,
      .extManual, .decelSel, .ctrlMode, .configState);
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic cfg(input logic st, input logic [15:0] v);
      @(posedge ref_clk);
      stopModeWr <= st;
      ctrlTypeWr <= !st;
      cfgData <= v;
      @(posedge ref_clk);
      stopModeWr <= 1'b0;
      ctrlTypeWr <= 1'b0;
      tick(2);
   endtask : cfg
   task automatic t_src();
      `CHK("stop mode", 16'h0000, stopModeRd)
      `CHK("ctrl type", 16'h0000, ctrlTypeRd)
      for (int s = 0; s < 4; s++) begin
         src.send(2'(s), 16'h0100 + 16'(s));
         #1;
         `CHK("rejected", s != 2, wrRejected)
      end
      `CHK("word", 16'h0102, cmdWordRd)
      // logic program as the selected source, network now refused
      @(posedge ref_clk);
      activeSrc <= 2'h3;
      src.send(2'h3, 16'h0003);
      #1;
      `CHK("rejected", 1'b0, wrRejected)
      src.send(2'h2, 16'h0004);
      #1;
      `CHK("rejected", 1'b1, wrRejected)
      `CHK("word", 16'h0003, cmdWordRd)
      @(posedge ref_clk);
      activeSrc <= 2'h2;
   endtask : t_src
   task automatic t_bits();
      for (int i = 0; i < 2; i++) begin
         w = i ? 16'hdfca : 16'h2035;
         src.send(2'h2, w);
         tick(2);
         `CHK("word", w, cmdWordRd)
         `CHK("run", w[0], runReq)
         `CHK("enable", w[1], driveEnable)
         `CHK("cw", w[2], dirCw)
         `CHK("inch", w[3], inchingActive)
         `CHK("remote", w[4], remoteMode)
         `CHK("ramp2", w[5], rampSet2)
         `CHK("qstop", w[6], quickStopActive)
         `CHK("decel", w[6] ? 2'h2 : {1'b0, w[5]}, decelSel)
         `CHK("intman", w[13], intManual)
         `CHK("extman", w[14], extManual)
         `CHK("fclear", 1'b0, faultClear)
      end
      @(posedge ref_clk);
      faultState <= 1'b1;
      tick(2);
      `CHK("fclear", 1'b1, faultClear)
   endtask : t_bits
   task automatic t_stop();
      for (int m = 0; m < 4; m++) begin
         cfg(1'b1, 16'(m));
         `CHK("stop mode", 16'(m == 3 ? 2 : m), stopModeRd)
         src.send(2'h2, 16'h0002);
         tick(2);
         `CHK("coast", m == 1, coastCut)
         `CHK("enable", m != 1, driveEnable)
         `CHK("rampdown", m != 1, rampDown)
         `CHK("decel", m >= 2 ? 2'h2 : 2'h0, decelSel)
         `CHK("fclear", 1'b0, faultClear)
      end
      cfg(1'b1, 16'h0001);
      // digital input stop in coast mode cuts drive; drive returns once the pin drops
      src.send(2'h2, 16'h0003);
      @(posedge ref_clk);
      diStopPin <= 1'b1;
      tick(4);
      `CHK("coast", 1'b1, coastCut)
      `CHK("run", 1'b0, runReq)
      @(posedge ref_clk);
      diStopPin <= 1'b0;
      tick(4);
      `CHK("enable", 1'b1, driveEnable)
   endtask : t_stop
   task automatic t_ctype();
      e = 16'h0000;
      for (int v = 0; v < 6; v++) begin
         cfg(1'b0, 16'(v));
         if (v != 1 && v != 2) e = 16'(v);
         `CHK("ctrl type", e, ctrlTypeRd)
         `CHK("ctrl mode", e[2:0], ctrlMode)
      end
      @(posedge ref_clk);
      frameSmallPin <= 1'b1;
      tick(4);
      `CHK("config", 1'b1, configState)
      `CHK("enable", 1'b0, driveEnable)
   endtask : t_ctype
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   initial begin
      repeat (2000) @(posedge ref_clk);
      n_mismatch++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      tick(2);
      t_src();
      t_bits();
      t_stop();
      t_ctype();
      conclude();
   end
endmodule : tb_top
